// File: common/dvgb_pkg.sv
// Purpose: constants for the delta velocity and gyro offset register block
// Assumes: AXI4-Lite slave, 32-bit data, one 40 MHz clock
// Notes: register index times four gives the byte address
// Operation
// [RULE1] x velocity change lower word, read only, index 0x30, no reset value
// [RULE2] x velocity change upper word, read only, index 0x32, two's complement
// [RULE3] y velocity change lower word, read only, index 0x34
// [RULE4] y velocity change upper word, read only, index 0x36, two's complement
// [RULE5] z velocity change lower word, read only, index 0x38
// [RULE6] z velocity change upper word, read only, index 0x3a, two's complement
// [RULE7] upper word alone is 16-bit two's complement, 0x8000 most negative
// [RULE8] upper and lower words form one 32-bit two's complement value
// [RULE9] offsets applied right after factory correction, chain ticks at 2000 Hz
// [RULE10] factory coefficients never visible; only offsets are writable; the code also takes writes to the decimation word at index 0x70
// [RULE11] x gyro offset lower word, read/write, index 0x40, resets to zero
// [RULE12] x gyro offset upper word, read/write, index 0x42, resets to zero
// [RULE13] y gyro offset lower word, read/write, index 0x44, resets to zero
// [RULE14] y gyro offset upper word, read/write, index 0x46, resets to zero
// [RULE15] x offset words join into 32 bits and add to x gyro data
// [RULE16] y offset words join into 32 bits and add to y gyro data
// [RULE17] velocity change sums successive sample pairs over decimation period, halved
// [RULE18] upper word is the high half, lower word the low half
// [RULE19] both words of all axes update on the same edge
// [RULE20] new offset used from next tick; zero offset leaves data unchanged

package dvgb_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int WORD_W = 16;
   localparam int DEC_W = 11;
   localparam int ACC_W = 48;
   localparam int TICK_W = 15;

   localparam logic [7:0] IDX_X_VEL_LOWER = 8'h30;
   localparam logic [7:0] IDX_X_VEL_UPPER = 8'h32;
   localparam logic [7:0] IDX_Y_VEL_LOWER = 8'h34;
   localparam logic [7:0] IDX_Y_VEL_UPPER = 8'h36;
   localparam logic [7:0] IDX_Z_VEL_LOWER = 8'h38;
   localparam logic [7:0] IDX_Z_VEL_UPPER = 8'h3a;
   localparam logic [7:0] IDX_X_GYRO_OFS_LOWER = 8'h40;
   localparam logic [7:0] IDX_X_GYRO_OFS_UPPER = 8'h42;
   localparam logic [7:0] IDX_Y_GYRO_OFS_LOWER = 8'h44;
   localparam logic [7:0] IDX_Y_GYRO_OFS_UPPER = 8'h46;
   localparam logic [7:0] IDX_DECIMATION = 8'h70;

   localparam logic [WORD_W-1:0] OFFSET_RESET = 16'h0000;
   localparam logic [DEC_W-1:0] DECIMATION_RESET = 11'h000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   localparam int CLOCK_HZ = 40_000_000;
   localparam int SAMPLE_RATE_HZ = 2000;
   localparam int SAMPLE_PERIOD_CYCLES = CLOCK_HZ / SAMPLE_RATE_HZ;

   typedef enum logic [0:0]
   {
      DVGB_PRIME = 1'b0,
      DVGB_RUN = 1'b1
   } dvgb_integ_state_t;
endpackage : dvgb_pkg

// File: rtl/dvgb_regs.sv
// Purpose: velocity change results and gyro offset correction behind AXI4-Lite
// Assumes: sensor words arrive factory corrected on this clock
// Notes: flash backup of offsets lives outside; offsets restart at zero here
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps

module dvgb_regs
#(
   parameter int SAMPLE_PERIOD = dvgb_pkg::SAMPLE_PERIOD_CYCLES
)
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [dvgb_pkg::ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [dvgb_pkg::DATA_W-1:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [dvgb_pkg::ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [dvgb_pkg::DATA_W-1:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic [31:0] accel_x_in,
   input wire logic [31:0] accel_y_in,
   input wire logic [31:0] accel_z_in,
   input wire logic [31:0] gyro_x_in,
   input wire logic [31:0] gyro_y_in,
   output logic [31:0] gyro_x_out,
   output logic [31:0] gyro_y_out,
   output logic gyro_valid_out,
   output logic velocity_ready_out
);
   import dvgb_pkg::*;

   function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      byte_addr = {2'b00, idx, 2'b00};
   endfunction : byte_addr

   // two's complement add that clamps instead of wrapping
   function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
      logic [32:0] s;
      s = {a[31], a} + {b[31], b};
      if (s[32] != s[31])
         sat_add = s[32] ? 32'h80000000 : 32'h7fffffff;
      else
         sat_add = s[31:0];
   endfunction : sat_add

   function automatic logic [31:0] sat_half(input logic [ACC_W-1:0] acc);
      logic [ACC_W-1:0] h;
      h = $signed(acc) >>> 1;
      if ($signed(h) > $signed({{(ACC_W-32){1'b0}}, 32'h7fffffff}))
         sat_half = 32'h7fffffff;
      else if ($signed(h) < $signed({{(ACC_W-32){1'b1}}, 32'h80000000}))
         sat_half = 32'h80000000;
      else
         sat_half = h[31:0];
   endfunction : sat_half

   function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [31:0] wd,
                                               input logic [3:0] st);
      merge_lanes = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
   endfunction : merge_lanes

   function automatic logic [ACC_W-1:0] widen(input logic [31:0] v);
      widen = {{(ACC_W-32){v[31]}}, v};
   endfunction : widen

   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [15:0] x_gyro_offset_lower_q;
   logic [15:0] x_gyro_offset_upper_q;
   logic [15:0] y_gyro_offset_lower_q;
   logic [15:0] y_gyro_offset_upper_q;
   logic [DEC_W-1:0] decimation_setting_q;
   logic [TICK_W-1:0] tick_count_q;
   logic tick_q;
   dvgb_integ_state_t integ_state_q;
   logic [DEC_W-1:0] dec_count_q;
   logic [2:0][31:0] prev_accel_q;
   logic [2:0][ACC_W-1:0] acc_q;
   logic [2:0][31:0] velocity_q;
   logic [31:0] gyro_x_q;
   logic [31:0] gyro_y_q;
   logic gyro_valid_q;
   logic velocity_ready_q;

   wire aw_take = s_axi_awvalid_in && awready_q;
   wire w_take = s_axi_wvalid_in && wready_q;
   wire write_fire = !awready_q && !wready_q && !bvalid_q;
   wire b_done = bvalid_q && s_axi_bready_in;
   wire ar_take = s_axi_arvalid_in && arready_q;
   wire r_done = rvalid_q && s_axi_rready_in;

   // only the offsets and the decimation word take writes
   wire wr_x_lower = write_fire && (awaddr_q == byte_addr(IDX_X_GYRO_OFS_LOWER));
   wire wr_x_upper = write_fire && (awaddr_q == byte_addr(IDX_X_GYRO_OFS_UPPER));
   wire wr_y_lower = write_fire && (awaddr_q == byte_addr(IDX_Y_GYRO_OFS_LOWER));
   wire wr_y_upper = write_fire && (awaddr_q == byte_addr(IDX_Y_GYRO_OFS_UPPER));
   wire wr_dec = write_fire && (awaddr_q == byte_addr(IDX_DECIMATION));
   wire wr_hit = wr_x_lower || wr_x_upper || wr_y_lower || wr_y_upper || wr_dec;

   wire [31:0] x_offset = {x_gyro_offset_upper_q, x_gyro_offset_lower_q}; // RULE15
   wire [31:0] y_offset = {y_gyro_offset_upper_q, y_gyro_offset_lower_q}; // RULE16

   logic [31:0] rd_word;
   logic rd_hit;
   always_comb
   begin
      rd_word = 32'h00000000;
      rd_hit = 1'b1;
      if (s_axi_araddr_in == byte_addr(IDX_X_VEL_LOWER))
         rd_word = {16'h0000, velocity_q[0][15:0]}; // RULE1 RULE18
      else if (s_axi_araddr_in == byte_addr(IDX_X_VEL_UPPER))
         rd_word = {16'h0000, velocity_q[0][31:16]}; // RULE2 RULE7 RULE18
      else if (s_axi_araddr_in == byte_addr(IDX_Y_VEL_LOWER))
         rd_word = {16'h0000, velocity_q[1][15:0]}; // RULE3
      else if (s_axi_araddr_in == byte_addr(IDX_Y_VEL_UPPER))
         rd_word = {16'h0000, velocity_q[1][31:16]}; // RULE4
      else if (s_axi_araddr_in == byte_addr(IDX_Z_VEL_LOWER))
         rd_word = {16'h0000, velocity_q[2][15:0]}; // RULE5
      else if (s_axi_araddr_in == byte_addr(IDX_Z_VEL_UPPER))
         rd_word = {16'h0000, velocity_q[2][31:16]}; // RULE6
      else if (s_axi_araddr_in == byte_addr(IDX_X_GYRO_OFS_LOWER))
         rd_word = {16'h0000, x_gyro_offset_lower_q}; // RULE11
      else if (s_axi_araddr_in == byte_addr(IDX_X_GYRO_OFS_UPPER))
         rd_word = {16'h0000, x_gyro_offset_upper_q}; // RULE12
      else if (s_axi_araddr_in == byte_addr(IDX_Y_GYRO_OFS_LOWER))
         rd_word = {16'h0000, y_gyro_offset_lower_q}; // RULE13
      else if (s_axi_araddr_in == byte_addr(IDX_Y_GYRO_OFS_UPPER))
         rd_word = {16'h0000, y_gyro_offset_upper_q}; // RULE14
      else if (s_axi_araddr_in == byte_addr(IDX_DECIMATION))
         rd_word = {21'h0, decimation_setting_q};
      else
         rd_hit = 1'b0; // RULE10
   end

   // write channel: address and data taken in either order, one write in flight
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end
      else
      begin
         if (aw_take)
         begin
            awaddr_q <= s_axi_awaddr_in;
            awready_q <= 1'b0;
         end
         if (w_take)
         begin
            wdata_q <= s_axi_wdata_in;
            wstrb_q <= s_axi_wstrb_in;
            wready_q <= 1'b0;
         end
         if (write_fire)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR; // RULE10
         end
         else if (b_done)
         begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= '0;
      end
      else if (ar_take)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (r_done)
      begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // read-only words have no write path at all
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         x_gyro_offset_lower_q <= OFFSET_RESET; // RULE11
         x_gyro_offset_upper_q <= OFFSET_RESET; // RULE12
         y_gyro_offset_lower_q <= OFFSET_RESET; // RULE13
         y_gyro_offset_upper_q <= OFFSET_RESET; // RULE14
         decimation_setting_q <= DECIMATION_RESET;
      end
      else
      begin
         if (wr_x_lower)
            x_gyro_offset_lower_q <= merge_lanes(x_gyro_offset_lower_q, wdata_q, wstrb_q); // RULE11
         if (wr_x_upper)
            x_gyro_offset_upper_q <= merge_lanes(x_gyro_offset_upper_q, wdata_q, wstrb_q); // RULE12
         if (wr_y_lower)
            y_gyro_offset_lower_q <= merge_lanes(y_gyro_offset_lower_q, wdata_q, wstrb_q); // RULE13
         if (wr_y_upper)
            y_gyro_offset_upper_q <= merge_lanes(y_gyro_offset_upper_q, wdata_q, wstrb_q); // RULE14
         if (wr_dec)
            decimation_setting_q <= {st_hi(wstrb_q[1], wdata_q[10:8], decimation_setting_q[10:8]),
                                     wstrb_q[0] ? wdata_q[7:0] : decimation_setting_q[7:0]};
      end
   end

   function automatic logic [2:0] st_hi(input logic en, input logic [2:0] nw, input logic [2:0] old);
      st_hi = en ? nw : old;
   endfunction : st_hi

   // processing tick for the sensor chain
   wire tick_wrap = (tick_count_q == TICK_W'(SAMPLE_PERIOD - 1));
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         tick_count_q <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_count_q <= tick_wrap ? '0 : tick_count_q + 1'b1; // RULE9
         tick_q <= tick_wrap; // RULE9
      end
   end

   // offset adds after the factory stage; offset sampled on the tick itself
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         gyro_x_q <= '0;
         gyro_y_q <= '0;
         gyro_valid_q <= 1'b0;
      end
      else
      begin
         gyro_valid_q <= tick_q;
         if (tick_q)
         begin
            gyro_x_q <= sat_add(gyro_x_in, x_offset); // RULE15 RULE20 RULE9
            gyro_y_q <= sat_add(gyro_y_in, y_offset); // RULE16 RULE20 RULE9
         end
      end
   end

   // integrator: first tick only primes the previous sample
   wire period_end = (dec_count_q >= decimation_setting_q);
   logic [2:0][31:0] accel_now;
   assign accel_now = {accel_z_in, accel_y_in, accel_x_in};

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         integ_state_q <= DVGB_PRIME;
         dec_count_q <= '0;
         prev_accel_q <= '0;
         acc_q <= '0;
         velocity_q <= '0;
         velocity_ready_q <= 1'b0;
      end
      else
      begin
         velocity_ready_q <= 1'b0;
         if (tick_q)
         begin
            prev_accel_q <= accel_now;
            case (integ_state_q)
               DVGB_PRIME:
               begin
                  integ_state_q <= DVGB_RUN;
               end
               DVGB_RUN:
               begin
                  for (int i = 0; i < 3; i++)
                  begin
                     if (period_end)
                     begin
                        // RULE17 RULE8 RULE19
                        velocity_q[i] <= sat_half(acc_q[i] + widen(accel_now[i]) + widen(prev_accel_q[i]));
                        acc_q[i] <= '0;
                     end
                     else
                        acc_q[i] <= acc_q[i] + widen(accel_now[i]) + widen(prev_accel_q[i]); // RULE17
                  end
                  dec_count_q <= period_end ? '0 : dec_count_q + 1'b1;
                  velocity_ready_q <= period_end; // RULE19
               end
               default:
               begin
                  integ_state_q <= DVGB_PRIME;
               end
            endcase
         end
      end
   end

   assign s_axi_awready_out = awready_q;
   assign s_axi_wready_out = wready_q;
   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out = bresp_q;
   assign s_axi_arready_out = arready_q;
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rresp_out = rresp_q;
   assign s_axi_rdata_out = rdata_q;
   assign gyro_x_out = gyro_x_q;
   assign gyro_y_out = gyro_y_q;
   assign gyro_valid_out = gyro_valid_q;
   assign velocity_ready_out = velocity_ready_q;

   a_x_offset_add: assert property (@(posedge clock_in) disable iff (!reset_n_in) // RULE15
      tick_q |=> gyro_x_out == sat_add($past(gyro_x_in), $past(x_offset)))
      else $error("x gyro output not raw plus offset");

   a_y_offset_add: assert property (@(posedge clock_in) disable iff (!reset_n_in) // RULE16
      tick_q |=> gyro_y_out == sat_add($past(gyro_y_in), $past(y_offset)))
      else $error("y gyro output not raw plus offset");

   a_zero_offset_pass: assert property (@(posedge clock_in) disable iff (!reset_n_in) // RULE20
      (tick_q && x_offset == 32'h00000000) |=> gyro_x_out == $past(gyro_x_in))
      else $error("zero offset changed x gyro data");

   a_tick_spacing: assert property (@(posedge clock_in) disable iff (!reset_n_in) // RULE9
      tick_q |=> !tick_q [*8])
      else $error("processing tick repeated too soon");

   a_words_together: assert property (@(posedge clock_in) disable iff (!reset_n_in) // RULE19
      ($changed(velocity_q[0][15:0]) || $changed(velocity_q[2][31:16])) |-> velocity_ready_out)
      else $error("velocity words changed outside a result update");

   a_read_upper_word: assert property (@(posedge clock_in) disable iff (!reset_n_in) // RULE18
      (ar_take && s_axi_araddr_in == byte_addr(IDX_X_VEL_UPPER) && !velocity_ready_q && !tick_q)
      |=> s_axi_rvalid_out && s_axi_rdata_out == {16'h0000, velocity_q[0][31:16]})
      else $error("x upper word read wrong half");

   a_hidden_unmapped: assert property (@(posedge clock_in) disable iff (!reset_n_in) // RULE10
      (ar_take && !rd_hit) |=> s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == 32'h00000000)
      else $error("unmapped read not refused");

   a_write_response: assert property (@(posedge clock_in) disable iff (!reset_n_in) // RULE11
      (aw_take && w_take) |=> ##1 s_axi_bvalid_out)
      else $error("write response late");

   a_offset_write: assert property (@(posedge clock_in) disable iff (!reset_n_in) // RULE12
      (wr_x_upper && wstrb_q[1:0] == 2'b11) |=> x_gyro_offset_upper_q == $past(wdata_q[15:0]))
      else $error("x upper offset write lost");

   a_pair_sum: assert property (@(posedge clock_in) disable iff (!reset_n_in) // RULE17
      (tick_q && integ_state_q == DVGB_RUN && decimation_setting_q == 11'h000)
      |=> velocity_ready_out && velocity_q[1] == sat_half($past(widen(accel_y_in)) + $past(widen(prev_accel_q[1]))))
      else $error("single pair velocity change wrong");
endmodule : dvgb_regs

// File: bench/dvgb_host.sv
// Purpose: host model issuing register bus cycles to the velocity and offset block
// Assumes: AXI4-Lite, one write and one read at most, signals change right after rising edges
// Notes: waits carry no bound of their own; the bench watchdog cuts a hang short
`timescale 1ns/10ps

module dvgb_host
(
   input wire logic clock_in,
   output logic [dvgb_pkg::ADDR_W-1:0] m_axi_awaddr_out,
   output logic m_axi_awvalid_out,
   input wire logic m_axi_awready_in,
   output logic [dvgb_pkg::DATA_W-1:0] m_axi_wdata_out,
   output logic [3:0] m_axi_wstrb_out,
   output logic m_axi_wvalid_out,
   input wire logic m_axi_wready_in,
   input wire logic [1:0] m_axi_bresp_in,
   input wire logic m_axi_bvalid_in,
   output logic m_axi_bready_out,
   output logic [dvgb_pkg::ADDR_W-1:0] m_axi_araddr_out,
   output logic m_axi_arvalid_out,
   input wire logic m_axi_arready_in,
   input wire logic [dvgb_pkg::DATA_W-1:0] m_axi_rdata_in,
   input wire logic [1:0] m_axi_rresp_in,
   input wire logic m_axi_rvalid_in,
   output logic m_axi_rready_out
);
   import dvgb_pkg::*;

   initial
   begin
      {m_axi_awaddr_out, m_axi_awvalid_out, m_axi_wdata_out, m_axi_wstrb_out} <= '0;
      {m_axi_wvalid_out, m_axi_bready_out, m_axi_araddr_out, m_axi_arvalid_out, m_axi_rready_out} <= '0;
   end

   // address and data offered together, each released on its own take
   task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [3:0] s,
                            output logic [1:0] resp);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clock_in);
      m_axi_awaddr_out <= a;
      m_axi_awvalid_out <= 1'b1;
      m_axi_wdata_out <= d;
      m_axi_wstrb_out <= s;
      m_axi_wvalid_out <= 1'b1;
      m_axi_bready_out <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge clock_in);
         if (!aw_done && m_axi_awready_in === 1'b1)
         begin
            aw_done = 1'b1;
            m_axi_awvalid_out <= 1'b0;
         end
         if (!w_done && m_axi_wready_in === 1'b1)
         begin
            w_done = 1'b1;
            m_axi_wvalid_out <= 1'b0;
         end
      end
      do
         @(posedge clock_in);
      while (m_axi_bvalid_in !== 1'b1);
      resp = m_axi_bresp_in;
      m_axi_bready_out <= 1'b0;
   endtask : write_reg

   task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] resp);
      @(posedge clock_in);
      m_axi_araddr_out <= a;
      m_axi_arvalid_out <= 1'b1;
      m_axi_rready_out <= 1'b1;
      do
         @(posedge clock_in);
      while (m_axi_arready_in !== 1'b1);
      m_axi_arvalid_out <= 1'b0;
      do
         @(posedge clock_in);
      while (m_axi_rvalid_in !== 1'b1);
      d = m_axi_rdata_in;
      resp = m_axi_rresp_in;
      m_axi_rready_out <= 1'b0;
   endtask : read_reg
endmodule : dvgb_host

// File: bench/dvgb_regs_bench.sv
// Purpose: self-checking bench for the velocity change and gyro offset registers
// Assumes: short sample period of 16 clocks so that ticks come often
// Notes: pulses are sampled on the falling edge, where registered outputs have settled
`timescale 1ns/10ps

module dvgb_regs_bench;
   import dvgb_pkg::*;
   localparam int PERIOD = 16;
   logic clock_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp;
   logic [31:0] accel_x = '0, accel_y = '0, accel_z = '0, gyro_x = '0, gyro_y = '0, gx_seen, gy_seen;
   logic gyro_valid, vel_ready;
   int failures = 0;
   int n_checks = 0;

   always #12.5 clock_in = ~clock_in;

   dvgb_regs #(.SAMPLE_PERIOD(PERIOD)) dvgb_regs_inst (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .accel_x_in(accel_x), .accel_y_in(accel_y), .accel_z_in(accel_z), .gyro_x_in(gyro_x),
      .gyro_y_in(gyro_y), .gyro_x_out(gx_seen), .gyro_y_out(gy_seen), .gyro_valid_out(gyro_valid),
      .velocity_ready_out(vel_ready));

   dvgb_host dvgb_host_inst (.clock_in(clock_in), .m_axi_awaddr_out(awaddr), .m_axi_awvalid_out(awvalid),
      .m_axi_awready_in(awready), .m_axi_wdata_out(wdata), .m_axi_wstrb_out(wstrb), .m_axi_wvalid_out(wvalid),
      .m_axi_wready_in(wready), .m_axi_bresp_in(bresp), .m_axi_bvalid_in(bvalid), .m_axi_bready_out(bready),
      .m_axi_araddr_out(araddr), .m_axi_arvalid_out(arvalid), .m_axi_arready_in(arready),
      .m_axi_rdata_in(rdata), .m_axi_rresp_in(rresp), .m_axi_rvalid_in(rvalid), .m_axi_rready_out(rready));

   function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : ba

   task automatic check(input logic [31:0] seen, input logic [31:0] expected, input string what);
      n_checks++;
      if (seen !== expected)
      begin
         failures++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, seen, expected);
      end
   endtask : check

   task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      dvgb_host_inst.read_reg(a, d, r);
      check(d, ed, "read data");
      check({30'h0, r}, {30'h0, er}, "read response");
   endtask : rd_check

   task automatic wr_check(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
      logic [1:0] r;
      dvgb_host_inst.write_reg(a, d, s, r);
      check({30'h0, r}, {30'h0, er}, "write response");
   endtask : wr_check

   // counts falling edges up to the next pulse; bounded so a dead tick shows as a mismatch
   task automatic wait_pulse(input bit vel, output int n);
      n = 0;
      do
      begin
         @(negedge clock_in);
         n++;
      end
      while ((vel ? vel_ready : gyro_valid) !== 1'b1 && n < 2000);
      check({31'h0, n < 2000}, 32'h1, "pulse arrived");
   endtask : wait_pulse

   task automatic t_reset_offsets;
      rd_check(ba(IDX_X_GYRO_OFS_LOWER), 32'h0, RESP_OKAY);
      rd_check(ba(IDX_X_GYRO_OFS_UPPER), 32'h0, RESP_OKAY);
      rd_check(ba(IDX_Y_GYRO_OFS_LOWER), 32'h0, RESP_OKAY);
      rd_check(ba(IDX_Y_GYRO_OFS_UPPER), 32'h0, RESP_OKAY);
      $display("test reset_offsets done");
   endtask : t_reset_offsets

   // partial strobes: only lanes 0 and 1 carry, upper half reads zero
   task automatic t_offset_rw;
      wr_check(ba(IDX_X_GYRO_OFS_LOWER), 32'habcd1234, 4'hf, RESP_OKAY);
      wr_check(ba(IDX_X_GYRO_OFS_UPPER), 32'h1234ff77, 4'h2, RESP_OKAY);
      wr_check(ba(IDX_Y_GYRO_OFS_LOWER), 32'hffffff5a, 4'h1, RESP_OKAY);
      wr_check(ba(IDX_Y_GYRO_OFS_UPPER), 32'h00008001, 4'hf, RESP_OKAY);
      rd_check(ba(IDX_X_GYRO_OFS_LOWER), 32'h00001234, RESP_OKAY);
      rd_check(ba(IDX_X_GYRO_OFS_UPPER), 32'h0000ff00, RESP_OKAY);
      rd_check(ba(IDX_Y_GYRO_OFS_LOWER), 32'h0000005a, RESP_OKAY);
      rd_check(ba(IDX_Y_GYRO_OFS_UPPER), 32'h00008001, RESP_OKAY);
      $display("test offset_rw done");
   endtask : t_offset_rw

   task automatic t_refused;
      logic [7:0] ro[6] = '{IDX_X_VEL_LOWER, IDX_X_VEL_UPPER, IDX_Y_VEL_LOWER, IDX_Y_VEL_UPPER,
                            IDX_Z_VEL_LOWER, IDX_Z_VEL_UPPER};
      foreach (ro[i])
         wr_check(ba(ro[i]), 32'h5555, 4'hf, RESP_SLVERR);
      rd_check(ba(8'h01), 32'h0, RESP_SLVERR);
      rd_check(12'h101, 32'h0, RESP_SLVERR);
      wr_check(ba(8'hff), 32'h1, 4'hf, RESP_SLVERR);
      $display("test refused done");
   endtask : t_refused

   // offsets take hold on the next tick, so the third pulse is judged
   task automatic t_gyro;
      int n;
      wr_check(ba(IDX_X_GYRO_OFS_LOWER), 32'hfff0, 4'hf, RESP_OKAY);
      wr_check(ba(IDX_X_GYRO_OFS_UPPER), 32'hffff, 4'hf, RESP_OKAY);
      wr_check(ba(IDX_Y_GYRO_OFS_LOWER), 32'h0000, 4'hf, RESP_OKAY);
      wr_check(ba(IDX_Y_GYRO_OFS_UPPER), 32'h0001, 4'hf, RESP_OKAY);
      @(posedge clock_in);
      gyro_x <= 32'h00000100;
      gyro_y <= 32'h7fff8000;
      wait_pulse(1'b0, n);
      wait_pulse(1'b0, n);
      wait_pulse(1'b0, n);
      check(n, PERIOD, "gyro pulse spacing");
      check(gx_seen, 32'h000000f0, "x gyro corrected");
      check(gy_seen, 32'h7fffffff, "y gyro saturated");
      @(negedge clock_in);
      check({31'h0, gyro_valid}, 32'h0, "gyro pulse width");
      wr_check(ba(IDX_X_GYRO_OFS_LOWER), 32'h0, 4'hf, RESP_OKAY);
      wr_check(ba(IDX_X_GYRO_OFS_UPPER), 32'h0, 4'hf, RESP_OKAY);
      wr_check(ba(IDX_Y_GYRO_OFS_UPPER), 32'h0, 4'hf, RESP_OKAY);
      wait_pulse(1'b0, n);
      wait_pulse(1'b0, n);
      check(gx_seen, 32'h00000100, "x gyro unchanged");
      check(gy_seen, 32'h7fff8000, "y gyro unchanged");
      $display("test gyro done");
   endtask : t_gyro

   task automatic t_velocity;
      int n;
      @(posedge clock_in);
      accel_x <= 32'h12345678;
      accel_y <= 32'hfffffffe;
      accel_z <= 32'h80000000;
      repeat (3) wait_pulse(1'b1, n);
      @(negedge clock_in);
      check({31'h0, vel_ready}, 32'h0, "velocity pulse width");
      rd_check(ba(IDX_X_VEL_UPPER), 32'h1234, RESP_OKAY);
      rd_check(ba(IDX_X_VEL_LOWER), 32'h5678, RESP_OKAY);
      rd_check(ba(IDX_Y_VEL_UPPER), 32'hffff, RESP_OKAY);
      rd_check(ba(IDX_Y_VEL_LOWER), 32'hfffe, RESP_OKAY);
      rd_check(ba(IDX_Z_VEL_UPPER), 32'h8000, RESP_OKAY);
      rd_check(ba(IDX_Z_VEL_LOWER), 32'h0000, RESP_OKAY);
      wr_check(ba(IDX_DECIMATION), 32'h3, 4'hf, RESP_OKAY);
      @(posedge clock_in);
      accel_x <= 32'h1fffffff;
      accel_y <= 32'h7fffffff;
      accel_z <= 32'h00000001;
      repeat (3) wait_pulse(1'b1, n);
      wait_pulse(1'b1, n);
      check(n, 4 * PERIOD, "velocity pulse spacing");
      rd_check(ba(IDX_X_VEL_UPPER), 32'h7fff, RESP_OKAY);
      rd_check(ba(IDX_X_VEL_LOWER), 32'hfffc, RESP_OKAY);
      rd_check(ba(IDX_Y_VEL_UPPER), 32'h7fff, RESP_OKAY);
      rd_check(ba(IDX_Y_VEL_LOWER), 32'hffff, RESP_OKAY);
      rd_check(ba(IDX_Z_VEL_UPPER), 32'h0000, RESP_OKAY);
      rd_check(ba(IDX_Z_VEL_LOWER), 32'h0004, RESP_OKAY);
      $display("test velocity done");
   endtask : t_velocity

   task automatic close_out;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   initial
   begin
      repeat (5) @(posedge clock_in);
      reset_n_in <= 1'b1;
      t_reset_offsets();
      t_offset_rw();
      t_refused();
      t_gyro();
      t_velocity();
      close_out();
   end

   // whole run needs well under 2000 clocks; this leaves ample margin
   initial
   begin
      repeat (20000) @(posedge clock_in);
      failures++;
      $display("unexpected at %0t: watchdog expired", $time);
      close_out();
   end
endmodule : dvgb_regs_bench
